// File: hw/nbc_core.sv
// Execution datapath of the 4-bit nibble core with its data RAM.
// Assumes the program ROM answers ROM_ADDR on the same clock by the end of
// the second state of each machine cycle.
//
// Summary of operation
// [RULE1] Every machine cycle runs four states, each one clock period long.
// [RULE2] Add memory, with or without carry, into work register; carry updated.
// [RULE3] Subtract memory, with or without borrow, from work register; carry updated.
// [RULE4] Add or subtract immediate nibble takes two bytes, two cycles, updates carry.
// [RULE5] Decimal adjust fixes work register to BCD after add; two bytes, two cycles.
// [RULE6] AND, OR, XOR memory into work register in one cycle.
// [RULE7] AND, OR, XOR work register into memory, written back, one cycle.
// [RULE8] AND, OR, XOR immediate into work register; two bytes long.
// [RULE9] Increment and decrement work register in one cycle.
// [RULE10] Increment and decrement working register zero to four in one cycle.
// [RULE11] Increment and decrement memory through either pointer pair, written back.
// [RULE12] Move between work register and working registers both ways.
// [RULE13] Move between work register and memory via either pointer pair.
// [RULE14] Load immediate nibble into work register.
// [RULE15] Load eight-bit immediate into primary pointer pair, two cycles.
// [RULE16] Load eight-bit immediate into secondary pointer pair, two cycles.
// [RULE17] Load immediate nibble into fifth working register.
// [RULE18] Pointer pair address: higher register upper nibble, lower register lower.
// [RULE19] Increment and decrement results wrap modulo sixteen.
`timescale 1ns/100ps
`default_nettype none

module nbc_core (
   // Clock and reset
   input wire logic MCLK,
   input wire logic RESET_N,
   // Program ROM fetch
   output logic [nbc_pkg::NBC_PC_W-1:0] ROM_ADDR,
   input wire logic [7:0] ROM_DATA,
   // Status
   output logic [3:0] STATE,
   output logic [nbc_pkg::NBC_DATA_W-1:0] WORK_NIBBLE,
   output logic CARRY,
   output logic INSTR_DONE
);
   import nbc_pkg::*;

   nbc_state_t state_r;
   nbc_state_t state_nxt;
   logic [NBC_PC_W-1:0] pc_r;
   logic [7:0] op_r;
   logic [7:0] imm_r;
   logic second_r;
   logic done_r;
   logic [3:0] work_nibble_r;
   logic [3:0] work_nibble_nxt;
   logic carry_flag_r;
   logic carry_flag_nxt;
   logic [3:0] wr_r [NBC_NREG];
   logic [3:0] wr_nxt [NBC_NREG];
   logic two_byte;
   logic exec_now;
   logic use_sec;
   logic mem_we_nxt;
   logic [3:0] mem_wd_nxt;
   logic [2:0] rn;
   logic rn_ok;

   nbc_mem_if mem_if ();

   nbc_ram u_ram (
      .clk (MCLK),
      .port (mem_if)
   );

   // ==========================================================
   // Machine cycle sequencer
   // [RULE1] four states per cycle
   always_comb begin
      case (state_r)
         NBC_FIRST_CYCLE_STATE: state_nxt = NBC_SECOND_CYCLE_STATE;
         NBC_SECOND_CYCLE_STATE: state_nxt = NBC_THIRD_CYCLE_STATE;
         NBC_THIRD_CYCLE_STATE: state_nxt = NBC_FOURTH_CYCLE_STATE;
         NBC_FOURTH_CYCLE_STATE: state_nxt = NBC_FIRST_CYCLE_STATE;
         default: state_nxt = NBC_FIRST_CYCLE_STATE;
      endcase
   end

   always_ff @(posedge MCLK) begin
      if (!RESET_N) begin
         state_r <= NBC_FIRST_CYCLE_STATE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ==========================================================
   // Fetch
   // Address moves at the end of each cycle, so it is stable for all four states
   always_ff @(posedge MCLK) begin
      if (!RESET_N) begin
         pc_r <= NBC_RST_PC;
      end else if (state_r == NBC_FOURTH_CYCLE_STATE) begin
         pc_r <= pc_r + 12'h001;
      end
   end

   always_ff @(posedge MCLK) begin
      if (!RESET_N) begin
         op_r <= OP_NOP;
         imm_r <= NBC_RST_BYTE;
      end else if (state_r == NBC_SECOND_CYCLE_STATE) begin
         if (second_r) begin
            imm_r <= ROM_DATA;
         end else begin
            op_r <= ROM_DATA;
         end
      end
   end

   // [RULE4] two-byte opcodes
   always_comb begin
      case (op_r)
         OP_ADD_I, OP_SUB_I, OP_DECIMAL_ADJUST: two_byte = 1'b1;
         OP_AND_I, OP_OR_I, OP_XOR_I: two_byte = 1'b1;
         OP_LD_P0, OP_LD_P1, OP_LD_FIFTH: two_byte = 1'b1;
         default: two_byte = 1'b0;
      endcase
   end

   // Second cycle fetches the operand byte, execution waits for it
   always_ff @(posedge MCLK) begin
      if (!RESET_N) begin
         second_r <= 1'b0;
      end else if (state_r == NBC_FOURTH_CYCLE_STATE) begin
         second_r <= two_byte && !second_r;
      end
   end

   assign exec_now = (state_r == NBC_FOURTH_CYCLE_STATE) && (second_r || !two_byte);

   // ==========================================================
   // Data memory addressing
   // [RULE18] high register is the upper nibble
   always_comb begin
      case (op_r)
         OP_INC_M1, OP_DEC_M1, OP_LD_AM1, OP_ST_M1: use_sec = 1'b1;
         default: use_sec = 1'b0;
      endcase
   end

   assign mem_if.addr = use_sec ? {wr_r[3], wr_r[2]} : {wr_r[1], wr_r[0]};
   assign mem_if.wdata = mem_wd_nxt;
   assign mem_if.we = exec_now && mem_we_nxt;

   // ==========================================================
   // ALU and move network
   assign rn = op_r[2:0];
   assign rn_ok = (rn <= NBC_LAST_REG);

   always_comb begin
      work_nibble_nxt = work_nibble_r;
      carry_flag_nxt = carry_flag_r;
      mem_we_nxt = 1'b0;
      mem_wd_nxt = work_nibble_r;
      for (int i = 0; i < NBC_NREG; i++) begin
         wr_nxt[i] = wr_r[i];
      end
      case (op_r)
         // [RULE2] add memory
         OP_ADD_M: {carry_flag_nxt, work_nibble_nxt} =
            {1'b0, work_nibble_r} + {1'b0, mem_if.rdata};
         OP_ADC_M: {carry_flag_nxt, work_nibble_nxt} =
            {1'b0, work_nibble_r} + {1'b0, mem_if.rdata} + {4'h0, carry_flag_r};
         // [RULE3] carry holds the borrow
         OP_SUB_M: {carry_flag_nxt, work_nibble_nxt} =
            {1'b0, work_nibble_r} - {1'b0, mem_if.rdata};
         OP_SUB_BORROW_M: {carry_flag_nxt, work_nibble_nxt} =
            {1'b0, work_nibble_r} - {1'b0, mem_if.rdata} - {4'h0, carry_flag_r};
         // [RULE4] immediate add and subtract
         OP_ADD_I: {carry_flag_nxt, work_nibble_nxt} =
            {1'b0, work_nibble_r} + {1'b0, imm_r[3:0]};
         OP_SUB_I: {carry_flag_nxt, work_nibble_nxt} =
            {1'b0, work_nibble_r} - {1'b0, imm_r[3:0]};
         // [RULE5] decimal adjust
         OP_DECIMAL_ADJUST: begin
            if ((work_nibble_r > NBC_BCD_MAX) || carry_flag_r) begin
               work_nibble_nxt = work_nibble_r + NBC_BCD_FIX;
               carry_flag_nxt = 1'b1;
            end
         end
         // [RULE6] logic into work register
         OP_AND_M: work_nibble_nxt = work_nibble_r & mem_if.rdata;
         OP_OR_M: work_nibble_nxt = work_nibble_r | mem_if.rdata;
         OP_XOR_M: work_nibble_nxt = work_nibble_r ^ mem_if.rdata;
         // [RULE7] logic written back
         OP_AND_W: begin
            mem_wd_nxt = work_nibble_r & mem_if.rdata;
            mem_we_nxt = 1'b1;
         end
         OP_OR_W: begin
            mem_wd_nxt = work_nibble_r | mem_if.rdata;
            mem_we_nxt = 1'b1;
         end
         OP_XOR_W: begin
            mem_wd_nxt = work_nibble_r ^ mem_if.rdata;
            mem_we_nxt = 1'b1;
         end
         // [RULE8] logic with immediate
         OP_AND_I: work_nibble_nxt = work_nibble_r & imm_r[3:0];
         OP_OR_I: work_nibble_nxt = work_nibble_r | imm_r[3:0];
         OP_XOR_I: work_nibble_nxt = work_nibble_r ^ imm_r[3:0];
         // [RULE9] [RULE19] wrapping step of work register
         OP_INC_A: work_nibble_nxt = work_nibble_r + 4'h1;
         OP_DEC_A: work_nibble_nxt = work_nibble_r - 4'h1;
         // [RULE11] memory step, written back
         OP_INC_M0, OP_INC_M1: begin
            mem_wd_nxt = mem_if.rdata + 4'h1;
            mem_we_nxt = 1'b1;
         end
         OP_DEC_M0, OP_DEC_M1: begin
            mem_wd_nxt = mem_if.rdata - 4'h1;
            mem_we_nxt = 1'b1;
         end
         // [RULE13] moves with memory
         OP_LD_AM0, OP_LD_AM1: work_nibble_nxt = mem_if.rdata;
         OP_ST_M0, OP_ST_M1: mem_we_nxt = 1'b1;
         // [RULE15] primary pair load
         OP_LD_P0: begin
            wr_nxt[0] = imm_r[3:0];
            wr_nxt[1] = imm_r[7:4];
         end
         // [RULE16] secondary pair load
         OP_LD_P1: begin
            wr_nxt[2] = imm_r[3:0];
            wr_nxt[3] = imm_r[7:4];
         end
         // [RULE17] fifth register load
         OP_LD_FIFTH: wr_nxt[4] = imm_r[3:0];
         default: begin
            // [RULE14] immediate into work register
            if (op_r[7:4] == OP_MOVI_HI) begin
               work_nibble_nxt = op_r[3:0];
            end else if (rn_ok) begin
               // [RULE10] [RULE12] register group by index
               case (op_r[7:3])
                  OP_INCR_GRP: wr_nxt[rn] = wr_r[rn] + 4'h1;
                  OP_DECR_GRP: wr_nxt[rn] = wr_r[rn] - 4'h1;
                  OP_LDR_GRP: work_nibble_nxt = wr_r[rn];
                  OP_STR_GRP: wr_nxt[rn] = work_nibble_r;
                  default: work_nibble_nxt = work_nibble_r;
               endcase
            end
         end
      endcase
   end

   // ==========================================================
   // Architectural state
   always_ff @(posedge MCLK) begin
      if (!RESET_N) begin
         work_nibble_r <= NBC_RST_NIB;
         carry_flag_r <= NBC_RST_CARRY;
      end else if (exec_now) begin
         work_nibble_r <= work_nibble_nxt;
         carry_flag_r <= carry_flag_nxt;
      end
   end

   for (genvar g = 0; g < NBC_NREG; g++) begin : g_wr
      always_ff @(posedge MCLK) begin
         if (!RESET_N) begin
            wr_r[g] <= NBC_RST_NIB;
         end else if (exec_now) begin
            wr_r[g] <= wr_nxt[g];
         end
      end
   end

   always_ff @(posedge MCLK) begin
      if (!RESET_N) begin
         done_r <= 1'b0;
      end else begin
         done_r <= exec_now;
      end
   end

   assign ROM_ADDR = pc_r;
   assign STATE = state_r;
   assign WORK_NIBBLE = work_nibble_r;
   assign CARRY = carry_flag_r;
   assign INSTR_DONE = done_r;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (!RESET_N);

   state_walk_a: assert property ( // [RULE1]
      state_r == NBC_FIRST_CYCLE_STATE |=> state_r == NBC_SECOND_CYCLE_STATE
         ##1 state_r == NBC_THIRD_CYCLE_STATE ##1 state_r == NBC_FOURTH_CYCLE_STATE
         ##1 state_r == NBC_FIRST_CYCLE_STATE)
      else $error("machine cycle state order broken");

   add_carry_a: assert property ( // [RULE2]
      exec_now && op_r == OP_ADC_M |=> {carry_flag_r, work_nibble_r} ==
         5'($past(work_nibble_r)) + 5'($past(mem_if.rdata)) + 5'($past(carry_flag_r)))
      else $error("add with carry result wrong");

   sub_borrow_a: assert property ( // [RULE3]
      exec_now && op_r == OP_SUB_M |=>
         carry_flag_r == ($past(work_nibble_r) < $past(mem_if.rdata))
         && work_nibble_r == 4'($past(work_nibble_r) - $past(mem_if.rdata)))
      else $error("subtract result or borrow wrong");

   imm_two_cycle_a: assert property ( // [RULE4]
      state_r == NBC_FOURTH_CYCLE_STATE && !second_r && op_r == OP_ADD_I
         |-> !exec_now ##4 exec_now)
      else $error("immediate add not executed in second cycle");

   bcd_fix_a: assert property ( // [RULE5]
      exec_now && op_r == OP_DECIMAL_ADJUST && work_nibble_r > NBC_BCD_MAX |=>
         carry_flag_r && work_nibble_r == 4'($past(work_nibble_r) + NBC_BCD_FIX))
      else $error("decimal adjust wrong");

   or_mem_a: assert property ( // [RULE6]
      exec_now && op_r == OP_OR_M |=>
         work_nibble_r == ($past(work_nibble_r) | $past(mem_if.rdata)))
      else $error("OR with memory wrong");

   xor_back_a: assert property ( // [RULE7]
      exec_now && op_r == OP_XOR_W |-> mem_if.we
         && mem_if.wdata == (work_nibble_r ^ mem_if.rdata) ##1 $stable(work_nibble_r))
      else $error("XOR write back wrong");

   and_imm_a: assert property ( // [RULE8]
      exec_now && op_r == OP_AND_I |=>
         work_nibble_r == ($past(work_nibble_r) & $past(imm_r[3:0])))
      else $error("AND immediate wrong");

   work_wrap_a: assert property ( // [RULE19]
      exec_now && op_r == OP_INC_A && work_nibble_r == 4'hF |=> work_nibble_r == 4'h0)
      else $error("work register increment did not wrap");

   reg_step_a: assert property ( // [RULE10]
      exec_now && op_r == {OP_DECR_GRP, 3'h4} |=> wr_r[4] == 4'($past(wr_r[4]) - 4'h1))
      else $error("fifth register decrement wrong");

   mem_dec_a: assert property ( // [RULE11]
      exec_now && op_r == OP_DEC_M1 |-> mem_if.we
         && mem_if.addr == {wr_r[3], wr_r[2]} && mem_if.wdata == 4'(mem_if.rdata - 4'h1))
      else $error("memory decrement wrong");

   reg_move_a: assert property ( // [RULE12]
      exec_now && op_r == {OP_STR_GRP, 3'h2} |=> wr_r[2] == $past(work_nibble_r))
      else $error("move to working register wrong");

   mem_load_a: assert property ( // [RULE13]
      exec_now && op_r == OP_LD_AM0 |-> mem_if.addr == {wr_r[1], wr_r[0]}
         ##1 work_nibble_r == $past(mem_if.rdata))
      else $error("load from memory wrong");

   pair_load_a: assert property ( // [RULE15]
      exec_now && op_r == OP_LD_P0 |=> {wr_r[1], wr_r[0]} == $past(imm_r))
      else $error("primary pair load wrong");

   done_pulse_a: assert property ( // [RULE1]
      INSTR_DONE |-> state_r == NBC_FIRST_CYCLE_STATE ##1 !INSTR_DONE)
      else $error("completion pulse misplaced");

   adc_carry_c: cover property (exec_now && op_r == OP_ADC_M && carry_flag_r);
   bcd_fix_c: cover property (exec_now && op_r == OP_DECIMAL_ADJUST
      && work_nibble_r > NBC_BCD_MAX);
   mem_write_c: cover property (mem_if.we && use_sec);
   pair_load_c: cover property (exec_now && op_r == OP_LD_P1);

endmodule // nbc_core

`default_nettype wire

// File: hw/nbc_mem_if.sv
// Data RAM port between the datapath and its nibble memory.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none

interface nbc_mem_if;
   logic [nbc_pkg::NBC_ADDR_W-1:0] addr;
   logic [nbc_pkg::NBC_DATA_W-1:0] wdata;
   logic we;
   logic [nbc_pkg::NBC_DATA_W-1:0] rdata;

   modport ctrl (output addr, output wdata, output we, input rdata);
   modport ram (input addr, input wdata, input we, output rdata);
endinterface : nbc_mem_if

`default_nettype wire

// File: hw/nbc_pkg.sv
// Constants and types shared by the nibble core datapath and its data RAM.
// Assumes a single clock domain and synchronous active-low reset.
`default_nettype none

package nbc_pkg;

   // ==========================================================
   // Widths and depths
   localparam int NBC_DATA_W = 4;
   localparam int NBC_PC_W = 12;
   localparam int NBC_ADDR_W = 8;
   localparam int NBC_RAM_DEPTH = 256;
   localparam int NBC_NREG = 5;
   localparam int NBC_STATES_PER_CYCLE = 4;

   // ==========================================================
   // Values after reset
   localparam logic [NBC_PC_W-1:0] NBC_RST_PC = 12'h000;
   localparam logic [3:0] NBC_RST_NIB = 4'h0;
   localparam logic NBC_RST_CARRY = 1'b0;
   localparam logic [7:0] NBC_RST_BYTE = 8'h00;

   // ==========================================================
   // Machine cycle states, one-hot
   typedef enum logic [3:0] {
      NBC_FIRST_CYCLE_STATE = 4'h1,
      NBC_SECOND_CYCLE_STATE = 4'h2,
      NBC_THIRD_CYCLE_STATE = 4'h4,
      NBC_FOURTH_CYCLE_STATE = 4'h8
   } nbc_state_t;

   // ==========================================================
   // Opcode map
   localparam logic [7:0] OP_NOP = 8'h00;
   localparam logic [7:0] OP_ADD_M = 8'h01;
   localparam logic [7:0] OP_ADC_M = 8'h02;
   localparam logic [7:0] OP_SUB_M = 8'h03;
   localparam logic [7:0] OP_SUB_BORROW_M = 8'h04;
   localparam logic [7:0] OP_ADD_I = 8'h05;
   localparam logic [7:0] OP_SUB_I = 8'h06;
   localparam logic [7:0] OP_DECIMAL_ADJUST = 8'h07;
   localparam logic [7:0] OP_AND_M = 8'h08;
   localparam logic [7:0] OP_OR_M = 8'h09;
   localparam logic [7:0] OP_XOR_M = 8'h0A;
   localparam logic [7:0] OP_AND_W = 8'h0B;
   localparam logic [7:0] OP_OR_W = 8'h0C;
   localparam logic [7:0] OP_XOR_W = 8'h0D;
   localparam logic [7:0] OP_AND_I = 8'h0E;
   localparam logic [7:0] OP_OR_I = 8'h0F;
   localparam logic [7:0] OP_XOR_I = 8'h10;
   localparam logic [7:0] OP_INC_A = 8'h11;
   localparam logic [7:0] OP_DEC_A = 8'h12;
   localparam logic [7:0] OP_INC_M0 = 8'h13;
   localparam logic [7:0] OP_INC_M1 = 8'h14;
   localparam logic [7:0] OP_DEC_M0 = 8'h15;
   localparam logic [7:0] OP_DEC_M1 = 8'h16;
   localparam logic [7:0] OP_LD_AM0 = 8'h17;
   localparam logic [7:0] OP_LD_AM1 = 8'h18;
   localparam logic [7:0] OP_ST_M0 = 8'h19;
   localparam logic [7:0] OP_ST_M1 = 8'h1A;
   localparam logic [7:0] OP_LD_P0 = 8'h40;
   localparam logic [7:0] OP_LD_P1 = 8'h41;
   localparam logic [7:0] OP_LD_FIFTH = 8'h42;
   // Register groups: upper five bits, index n in bits 2:0
   localparam logic [4:0] OP_INCR_GRP = 5'h04;
   localparam logic [4:0] OP_DECR_GRP = 5'h05;
   localparam logic [4:0] OP_LDR_GRP = 5'h06;
   localparam logic [4:0] OP_STR_GRP = 5'h07;
   // Immediate to work register: upper nibble, data in low nibble
   localparam logic [3:0] OP_MOVI_HI = 4'h7;

   // ==========================================================
   // Arithmetic constants
   localparam logic [3:0] NBC_BCD_MAX = 4'h9;
   localparam logic [3:0] NBC_BCD_FIX = 4'h6;
   localparam logic [2:0] NBC_LAST_REG = 3'h4;

endpackage : nbc_pkg

`default_nettype wire

// File: hw/nbc_ram.sv
// Data memory of 256 nibbles with registered read data.
// Assumes address stays stable for one edge before the data are used.
`timescale 1ns/100ps
`default_nettype none

module nbc_ram (
   // Clock
   input wire logic clk,
   // Memory port
   nbc_mem_if.ram port
);
   import nbc_pkg::*;

   logic [NBC_DATA_W-1:0] mem_q [NBC_RAM_DEPTH];

   // ==========================================================
   // Storage
   // Contents are not reset, as on the real array
   always_ff @(posedge clk) begin
      if (port.we) begin
         mem_q[port.addr] <= port.wdata;
      end
   end

   // Read returns old data on a same-address write
   always_ff @(posedge clk) begin
      port.rdata <= mem_q[port.addr];
   end

endmodule // nbc_ram

`default_nettype wire

// File: test/nbc_rom_model.sv
// Program ROM model feeding instruction bytes to the nibble core.
// Assumes the bench writes each byte before the core fetches it.
`timescale 1ns/100ps
`default_nettype none

module nbc_rom_model (
   // Clock
   input wire logic clk,
   // Fetch port
   input wire logic [nbc_pkg::NBC_PC_W-1:0] addr,
   output logic [7:0] data,
   // Answer one clock late
   input wire logic slow
);
   import nbc_pkg::*;

   // ==========================================================
   // Storage
   logic [7:0] prog [0:255];
   logic [7:0] late_r;

   // Late answer still lands before the edge that ends the second state
   always_ff @(posedge clk) begin
      late_r <= prog[addr[7:0]];
   end

   assign data = slow ? late_r : prog[addr[7:0]];
endmodule // nbc_rom_model

`default_nettype wire

// File: test/tb_top.sv
// Self-checking bench for the nibble core datapath.
// Assumes the ROM model answers every fetch; results are read at INSTR_DONE.
`timescale 1ns/100ps
`default_nettype none

module tb_top;
   import nbc_pkg::*;

   logic mclk;
   logic rst_n;
   logic slow;
   logic [NBC_PC_W-1:0] rom_addr;
   logic [7:0] rom_data;
   logic [3:0] state;
   logic [3:0] work;
   logic carry;
   logic done;
   logic [3:0] prev_state;
   int failures;
   int n_compared;
   int wp;
   bit first;

   nbc_core uut (.MCLK(mclk), .RESET_N(rst_n), .ROM_ADDR(rom_addr), .ROM_DATA(rom_data),
      .STATE(state), .WORK_NIBBLE(work), .CARRY(carry), .INSTR_DONE(done));
   nbc_rom_model rom (.clk(mclk), .addr(rom_addr), .data(rom_data), .slow(slow));

   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   // ==========================================================
   // Verdict and compares
   task automatic end_of_test();
      if (failures == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic cmp_nib(input string what, input logic [3:0] exp, input logic [3:0] got);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("wrong value %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task automatic cmp_flag(input string what, input logic exp, input logic got);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("wrong value %s: expected %b, seen %b", what, exp, got);
      end
   endtask

   task automatic cmp_addr(input string what, input logic [11:0] exp, input logic [11:0] got);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("wrong value %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task automatic cmp_count(input string what, input int exp, input int got);
      n_compared++;
      if (got != exp) begin
         failures++;
         $display("wrong value %s: expected %0d, seen %0d", what, exp, got);
      end
   endtask

   // ==========================================================
   // State watch, settled two ns after each edge
   always @(posedge mclk) begin
      #2;
      if (rst_n === 1'b0) begin
         cmp_nib("state in reset", 4'h1, state);
      end else begin
         cmp_nib("state order", {prev_state[2:0], prev_state[3]}, state);
      end
      if (done !== 1'b0) begin
         cmp_nib("state at done", 4'h1, state);
      end
      prev_state = state;
   end

   // ==========================================================
   // Drivers
   task automatic restart(input logic late);
      int i;
      @(negedge mclk);
      rst_n = 1'b0;
      slow = late;
      for (i = 0; i < 256; i++) begin
         rom.prog[i] = OP_NOP;
      end
      repeat (10) @(negedge mclk);
      cmp_nib("work after reset", NBC_RST_NIB, work);
      cmp_flag("carry after reset", NBC_RST_CARRY, carry);
      cmp_addr("pc after reset", NBC_RST_PC, rom_addr);
      cmp_flag("done in reset", 1'b0, done);
      rst_n = 1'b1;
      wp = 0;
      first = 1'b1;
   endtask

   // Written in the first state, before the fetch of this address closes
   task automatic ins(input logic [7:0] op, input logic [7:0] imm, input logic [3:0] a,
      input logic c);
      int nb;
      int n;
      nb = (op inside {OP_ADD_I, OP_SUB_I, OP_DECIMAL_ADJUST, OP_AND_I, OP_OR_I, OP_XOR_I,
         OP_LD_P0, OP_LD_P1, OP_LD_FIFTH}) ? 2 : 1;
      rom.prog[wp] = op;
      rom.prog[wp + 1] = imm;
      wp = wp + nb;
      n = 0;
      do begin
         @(negedge mclk);
         n++;
      end while (done !== 1'b1 && n < 40);
      if (done !== 1'b1) begin
         failures++;
         end_of_test();
      end
      if (!first) begin
         cmp_count("cycles per instruction", 4 * nb, n);
      end
      first = 1'b0;
      cmp_addr("fetch address", wp[11:0], rom_addr);
      cmp_nib("work nibble", a, work);
      cmp_flag("carry", c, carry);
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_arith();
      restart(1'b0);
      ins(OP_LD_P0, 8'h10, 4'h0, 1'b0);
      ins(8'h79, 8'h00, 4'h9, 1'b0);
      ins(OP_ST_M0, 8'h00, 4'h9, 1'b0);
      ins(8'h78, 8'h00, 4'h8, 1'b0);
      ins(OP_ADD_M, 8'h00, 4'h1, 1'b1);
      ins(OP_ADC_M, 8'h00, 4'hB, 1'b0);
      ins(OP_SUB_M, 8'h00, 4'h2, 1'b0);
      ins(8'h73, 8'h00, 4'h3, 1'b0);
      ins(OP_SUB_M, 8'h00, 4'hA, 1'b1);
      ins(OP_SUB_BORROW_M, 8'h00, 4'h0, 1'b0);
      ins(OP_ADD_I, 8'h07, 4'h7, 1'b0);
      ins(OP_ADD_I, 8'hAC, 4'h3, 1'b1);
      ins(OP_DECIMAL_ADJUST, 8'h00, 4'h9, 1'b1);
      ins(OP_SUB_I, 8'h0A, 4'hF, 1'b1);
      ins(OP_DECIMAL_ADJUST, 8'h00, 4'h5, 1'b1);
      ins(OP_ADD_I, 8'h01, 4'h6, 1'b0);
      ins(OP_DECIMAL_ADJUST, 8'h00, 4'h6, 1'b0);
   endtask

   // Carry held high to show logic ops leave it alone
   task automatic t_logic();
      restart(1'b1);
      ins(8'h7F, 8'h00, 4'hF, 1'b0);
      ins(OP_ADD_I, 8'h01, 4'h0, 1'b1);
      ins(8'h79, 8'h00, 4'h9, 1'b1);
      ins(OP_ST_M0, 8'h00, 4'h9, 1'b1);
      ins(OP_LD_AM1, 8'h00, 4'h9, 1'b1);
      ins(8'h7C, 8'h00, 4'hC, 1'b1);
      ins(OP_AND_M, 8'h00, 4'h8, 1'b1);
      ins(8'h7C, 8'h00, 4'hC, 1'b1);
      ins(OP_OR_M, 8'h00, 4'hD, 1'b1);
      ins(OP_XOR_M, 8'h00, 4'h4, 1'b1);
      ins(OP_AND_W, 8'h00, 4'h4, 1'b1);
      ins(OP_LD_AM0, 8'h00, 4'h0, 1'b1);
      ins(8'h76, 8'h00, 4'h6, 1'b1);
      ins(OP_OR_W, 8'h00, 4'h6, 1'b1);
      ins(8'h73, 8'h00, 4'h3, 1'b1);
      ins(OP_XOR_W, 8'h00, 4'h3, 1'b1);
      ins(OP_LD_AM0, 8'h00, 4'h5, 1'b1);
      ins(OP_AND_I, 8'h3C, 4'h4, 1'b1);
      ins(OP_OR_I, 8'h03, 4'h7, 1'b1);
      ins(OP_XOR_I, 8'h0F, 4'h8, 1'b1);
   endtask

   task automatic t_incdec();
      int n;
      logic [3:0] v;
      logic [3:0] av;
      restart(1'b0);
      ins(8'h7F, 8'h00, 4'hF, 1'b0);
      ins(OP_INC_A, 8'h00, 4'h0, 1'b0);
      ins(OP_DEC_A, 8'h00, 4'hF, 1'b0);
      for (n = 0; n < 5; n++) begin
         v = 4'hE + n[3:0];
         ins({4'h7, v}, 8'h00, v, 1'b0);
         ins({OP_STR_GRP, n[2:0]}, 8'h00, v, 1'b0);
      end
      av = 4'h2;
      for (n = 0; n < 5; n++) begin
         v = 4'hE + n[3:0];
         ins({OP_INCR_GRP, n[2:0]}, 8'h00, av, 1'b0);
         ins({OP_LDR_GRP, n[2:0]}, 8'h00, v + 4'h1, 1'b0);
         ins({OP_DECR_GRP, n[2:0]}, 8'h00, v + 4'h1, 1'b0);
         ins({OP_LDR_GRP, n[2:0]}, 8'h00, v, 1'b0);
         av = v;
      end
      ins(OP_LD_FIFTH, 8'h07, 4'h2, 1'b0);
      ins({OP_LDR_GRP, NBC_LAST_REG}, 8'h00, 4'h7, 1'b0);
      ins(OP_LD_P0, 8'h5C, 4'h7, 1'b0);
      ins(OP_LD_P1, 8'hC5, 4'h7, 1'b0);
      ins(8'h7F, 8'h00, 4'hF, 1'b0);
      ins(OP_ST_M0, 8'h00, 4'hF, 1'b0);
      ins(OP_INC_M0, 8'h00, 4'hF, 1'b0);
      ins(OP_LD_AM0, 8'h00, 4'h0, 1'b0);
      ins(8'h70, 8'h00, 4'h0, 1'b0);
      ins(OP_ST_M1, 8'h00, 4'h0, 1'b0);
      ins(OP_DEC_M1, 8'h00, 4'h0, 1'b0);
      ins(OP_LD_AM1, 8'h00, 4'hF, 1'b0);
      ins({OP_LDR_GRP, 3'h0}, 8'h00, 4'hC, 1'b0);
      ins({OP_LDR_GRP, 3'h1}, 8'h00, 4'h5, 1'b0);
      ins(OP_LD_P1, 8'h5C, 4'h5, 1'b0);
      ins(OP_LD_AM1, 8'h00, 4'h0, 1'b0);
      // Both pairs now point at one nibble: step it through each in turn
      ins(OP_INC_M1, 8'h00, 4'h0, 1'b0);
      ins(OP_LD_AM0, 8'h00, 4'h1, 1'b0);
      ins(OP_DEC_M0, 8'h00, 4'h1, 1'b0);
      ins(OP_LD_AM1, 8'h00, 4'h0, 1'b0);
   endtask

   task automatic t_movi();
      int k;
      restart(1'b1);
      for (k = 0; k < 16; k++) begin
         ins({4'h7, k[3:0]}, 8'h00, k[3:0], 1'b0);
      end
   endtask

   initial begin
      rst_n = 1'b0;
      slow = 1'b0;
      failures = 0;
      n_compared = 0;
      wp = 0;
      first = 1'b1;
      prev_state = 4'h1;
      t_arith();
      t_logic();
      t_incdec();
      t_movi();
      end_of_test();
   end
endmodule // tb_top

`default_nettype wire
